// ### adc_guard_regs.vh
/*
 Register offsets, field positions, reset values and timing counts for
 the converter low-power control and window guard block.
 Assumes a 100 MHz CLK and word-aligned AXI4-Lite byte addresses.
*/
`ifndef ADC_GUARD_REGS_VH
`define ADC_GUARD_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_CTRL      8'h00
`define OFF_CFG       8'h04
`define OFF_STATUS    8'h08
`define OFF_IRQEN     8'h0C
`define OFF_RESULT    8'h10
`define OFF_G1CFG     8'h14
`define OFF_G1THR     8'h18
`define OFF_G2CFG     8'h1C
`define OFF_G2THR     8'h20
`define OFF_G3CFG     8'h24
`define OFF_G3THR     8'h28

// ****************************************
// Field positions
// ****************************************
`define CTRL_START    0
`define CTRL_STOP     1
`define CTRL_DISABLE  2
`define CFG_HOLD      0
`define CFG_PDOWN     1
`define CFG_CONT      2
`define CFG_RES_LO    3
`define ST_DONE       0
`define ST_GUARD_LO   1
`define ST_POWERED    4
`define ST_OSC        5
`define G1_EN         0
`define G1_SGL        1
`define G1_CH_LO      2
`define THR_LO_LO     0
`define THR_HI_LO     16

// ****************************************
// Reset values and timing
// ****************************************
`define CFG_RESET     5'h00
`define THR_RESET     32'h0FFF0000
`define THR_MASK      32'h0FFF0FFF
`define STARTUP_NS    1000
`define CONV_CYCLES   14

`endif

// ### adc_lowpower_window_guard.v
/*
 Converter low-power control (hold-until-read, power-down-when-idle) and
 three window guards with sticky flags and out signals, AXI4-Lite slave.
 Assumes the analog core raises CONV_DONE with CONV_CH/CONV_DATA once per
 conversion after CONV_START; all inputs share CLK except HW_TRIG.
*/
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "adc_guard_regs.vh"

module adc_lowpower_window_guard #(
   parameter CLK_MHZ = 100,
   parameter NCH     = 19
) (
   // Clock and reset
   input  wire        CLK,
   input  wire        RESET,
   // AXI4-Lite slave
   input  wire [7:0]  AWADDR,
   input  wire        AWVALID,
   output reg         AWREADY,
   input  wire [31:0] WDATA,
   input  wire [3:0]  WSTRB,
   input  wire        WVALID,
   output reg         WREADY,
   output reg  [1:0]  BRESP,
   output reg         BVALID,
   input  wire        BREADY,
   input  wire [7:0]  ARADDR,
   input  wire        ARVALID,
   output reg         ARREADY,
   output reg  [31:0] RDATA,
   output reg  [1:0]  RRESP,
   output reg         RVALID,
   input  wire        RREADY,
   // Analog core
   input  wire        HW_TRIG,
   input  wire        CONV_DONE,
   input  wire [4:0]  CONV_CH,
   input  wire [11:0] CONV_DATA,
   input  wire        SEQ_LAST,
   output reg         CONV_START,
   output reg         CONV_POWER_ON,
   output reg         OSC_ON,
   // Guard outputs
   output reg  [2:0]  GUARD_OUT,
   output reg         IRQ
);

   localparam STARTUP_CYC = (`STARTUP_NS * CLK_MHZ + 999) / 1000;

   localparam S_IDLE  = 3'd0;
   localparam S_WAKE  = 3'd1;
   localparam S_CONV  = 3'd2;
   localparam S_WAIT  = 3'd3;
   localparam S_NEXT  = 3'd4;

   // ****************************************
   // Trigger synchroniser
   // ****************************************
   reg        trig_s1_ff, trig_s2_ff, trig_s3_ff;
   always @(posedge CLK) begin
      if (RESET) begin
         trig_s1_ff <= 1'b0;
         trig_s2_ff <= 1'b0;
         trig_s3_ff <= 1'b0;
      end else begin
         trig_s1_ff <= HW_TRIG;
         trig_s2_ff <= trig_s1_ff;
         trig_s3_ff <= trig_s2_ff;
      end
   end
   wire trig_rise = trig_s2_ff & ~trig_s3_ff;

   // ****************************************
   // Bus slave
   // ****************************************
   reg        aw_got_ff, w_got_ff;
   reg [7:0]  aw_addr_ff;
   reg [31:0] w_data_ff;
   reg [3:0]  w_strb_ff;
   wire       wr_go = aw_got_ff & w_got_ff & ~BVALID;
   wire       wr_ok = (aw_addr_ff[1:0] == 2'b00) && (aw_addr_ff <= `OFF_G3THR);
   wire       wr_full = wr_go & wr_ok & (w_strb_ff == 4'hF);
   wire       rd_go = ARVALID & ARREADY;

   always @(posedge CLK) begin
      if (RESET) begin
         aw_got_ff  <= 1'b0;
         w_got_ff   <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff  <= 32'h00000000;
         w_strb_ff  <= 4'h0;
         AWREADY    <= 1'b0;
         WREADY     <= 1'b0;
         BVALID     <= 1'b0;
         BRESP      <= 2'b00;
         ARREADY    <= 1'b0;
      end else begin
         AWREADY <= ~aw_got_ff & ~AWREADY & ~(AWVALID & AWREADY);
         WREADY  <= ~w_got_ff & ~WREADY & ~(WVALID & WREADY);
         if (AWVALID & AWREADY) begin
            aw_got_ff  <= 1'b1;
            aw_addr_ff <= AWADDR;
         end
         if (WVALID & WREADY) begin
            w_got_ff  <= 1'b1;
            w_data_ff <= WDATA;
            w_strb_ff <= WSTRB;
         end
         if (wr_go) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            BVALID    <= 1'b1;
            BRESP     <= wr_ok ? 2'b00 : 2'b10;
         end else if (BVALID & BREADY) begin
            BVALID <= 1'b0;
         end
         ARREADY <= ~ARREADY & ~RVALID & ~rd_go;
      end
   end

   // ****************************************
   // Control and configuration registers
   // ****************************************
   reg [4:0]  cfg_ff;
   reg [31:0] irqen_ff;
   reg [6:0]  g1cfg_ff;
   reg [NCH-1:0] mask2_ff, mask3_ff;
   reg [31:0] thr_ff [0:2];
   reg [2:0]  thr_touch_ff;
   wire       hold_mode  = cfg_ff[`CFG_HOLD];
   wire       pdown_mode = cfg_ff[`CFG_PDOWN];
   wire       cont_mode  = cfg_ff[`CFG_CONT];
   wire [1:0] res_sel    = cfg_ff[`CFG_RES_LO+1:`CFG_RES_LO];
   wire       sw_start   = wr_full && aw_addr_ff == `OFF_CTRL && w_data_ff[`CTRL_START];
   wire       sw_stop    = wr_full && aw_addr_ff == `OFF_CTRL && w_data_ff[`CTRL_STOP];
   wire       sw_disable = wr_full && aw_addr_ff == `OFF_CTRL && w_data_ff[`CTRL_DISABLE];
   wire       clr_wr     = wr_full && aw_addr_ff == `OFF_STATUS;
   wire       res_read   = rd_go && ARADDR == `OFF_RESULT;

   always @(posedge CLK) begin
      if (RESET) begin
         cfg_ff   <= `CFG_RESET;
         irqen_ff <= 32'h00000000;
         g1cfg_ff <= 7'h00;
         mask2_ff <= {NCH{1'b0}};
         mask3_ff <= {NCH{1'b0}};
         thr_ff[0] <= `THR_RESET;
         thr_ff[1] <= `THR_RESET;
         thr_ff[2] <= `THR_RESET;
      end else if (wr_full) begin
         case (aw_addr_ff)
            `OFF_CFG:   cfg_ff    <= w_data_ff[4:0];
            `OFF_IRQEN: irqen_ff  <= {28'h0000000, w_data_ff[3:0]};
            `OFF_G1CFG: g1cfg_ff  <= w_data_ff[6:0];
            `OFF_G2CFG: mask2_ff  <= w_data_ff[NCH-1:0];
            `OFF_G3CFG: mask3_ff  <= w_data_ff[NCH-1:0];
            `OFF_G1THR: thr_ff[0] <= w_data_ff & `THR_MASK;
            `OFF_G2THR: thr_ff[1] <= w_data_ff & `THR_MASK;
            `OFF_G3THR: thr_ff[2] <= w_data_ff & `THR_MASK;
            default:    cfg_ff    <= cfg_ff;
         endcase
      end
   end

   // ****************************************
   // Conversion sequencer and power control
   // ****************************************
   reg [2:0]  state_ff, nxt_state;
   reg [15:0] cnt_ff, nxt_cnt;
   reg        done_ff;
   reg [11:0] result_ff;
   reg        busy_ff;
   // A start while powered down goes through the startup delay
   wire       start_req = sw_start | trig_rise;

   always @* begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         S_IDLE: if (start_req) begin
            if (pdown_mode) begin
               nxt_state = S_WAKE;
               nxt_cnt   = STARTUP_CYC[15:0];
            end else begin
               nxt_state = S_NEXT;
            end
         end
         S_WAKE: if (cnt_ff <= 16'd1) nxt_state = S_NEXT; else nxt_cnt = cnt_ff - 16'd1;
         // triggers are not looked at while converting or waiting
         S_NEXT: nxt_state = (hold_mode & done_ff) ? S_WAIT : S_CONV;
         S_CONV: if (CONV_DONE) begin
            if (SEQ_LAST & ~cont_mode) nxt_state = S_IDLE;
            else if (hold_mode) nxt_state = S_WAIT;
            else nxt_state = S_NEXT;
         end
         S_WAIT: if (~done_ff | res_read) begin
            // restart from powered-off wait goes through startup
            if (pdown_mode) begin
               nxt_state = S_WAKE;
               nxt_cnt   = STARTUP_CYC[15:0];
            end else begin
               nxt_state = S_CONV;
            end
         end
         default: nxt_state = S_IDLE;
      endcase
      if (sw_stop | sw_disable) nxt_state = S_IDLE;
   end

   always @(posedge CLK) begin
      if (RESET) begin
         state_ff      <= S_IDLE;
         cnt_ff        <= 16'h0000;
         CONV_START    <= 1'b0;
         CONV_POWER_ON <= 1'b0;
         OSC_ON        <= 1'b0;
         busy_ff       <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         CONV_START <= (nxt_state == S_CONV) && (state_ff != S_CONV);
         busy_ff    <= (nxt_state == S_CONV);
         // powered off in idle and hold-wait when enabled
         CONV_POWER_ON <= ~pdown_mode | ~(nxt_state == S_IDLE | nxt_state == S_WAIT);
         OSC_ON        <= ~pdown_mode | ~(nxt_state == S_IDLE | nxt_state == S_WAIT);
      end
   end

   // ****************************************
   // Result and done flag
   // ****************************************
   always @(posedge CLK) begin
      if (RESET) begin
         done_ff   <= 1'b0;
         result_ff <= 12'h000;
      end else begin
         if (CONV_DONE) result_ff <= CONV_DATA;
         // Set wins over a read or write-one clear in the same cycle
         if (CONV_DONE) done_ff <= 1'b1;
         else if (res_read | (clr_wr & w_data_ff[`ST_DONE])) done_ff <= 1'b0;
      end
   end

   // ****************************************
   // Window guards
   // ****************************************
   reg  [11:0] raw_cmp;
   always @* begin
      case (res_sel)
         2'b00:   raw_cmp = CONV_DATA;
         2'b01:   raw_cmp = {CONV_DATA[11:2], 2'b00};
         2'b10:   raw_cmp = {CONV_DATA[11:4], 4'h0};
         default: raw_cmp = {CONV_DATA[11:6], 6'h00};
      endcase
   end

   wire [2:0] guarded;
   assign guarded[0] = g1cfg_ff[`G1_EN] & (~g1cfg_ff[`G1_SGL] |
                       (CONV_CH == g1cfg_ff[`G1_CH_LO+4:`G1_CH_LO]));
   assign guarded[1] = |mask2_ff & mask2_ff[CONV_CH];
   assign guarded[2] = |mask3_ff & mask3_ff[CONV_CH];

   reg  [2:0] flag_ff, cmp_v_ff, cmp_out_ff, pipe_v_ff, pipe_out_ff;
   wire       thr_wr_any = wr_full && (aw_addr_ff == `OFF_G1THR ||
                           aw_addr_ff == `OFF_G2THR || aw_addr_ff == `OFF_G3THR);

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : guard
         wire [11:0] lo  = thr_ff[g][`THR_LO_LO+11:`THR_LO_LO];
         wire [11:0] hi  = thr_ff[g][`THR_HI_LO+11:`THR_HI_LO];
         wire        out = (raw_cmp < lo) | (raw_cmp > hi);
         wire        twr = thr_wr_any && aw_addr_ff == (`OFF_G1THR + 8'h08 * g);
         // threshold write during a conversion masks its check until next conversion starts
         wire        chk = CONV_DONE & guarded[g] & ~thr_touch_ff[g] & ~twr;
         always @(posedge CLK) begin
            if (RESET) begin
               thr_touch_ff[g] <= 1'b0;
               flag_ff[g]      <= 1'b0;
               cmp_v_ff[g]     <= 1'b0;
               cmp_out_ff[g]   <= 1'b0;
               pipe_v_ff[g]    <= 1'b0;
               pipe_out_ff[g]  <= 1'b0;
               GUARD_OUT[g]    <= 1'b0;
            end else begin
               if (twr & (busy_ff | CONV_START)) thr_touch_ff[g] <= 1'b1;
               else if (CONV_START) thr_touch_ff[g] <= 1'b0;
               // Set wins over write-one clear
               if (chk & out) flag_ff[g] <= 1'b1;
               else if (clr_wr & w_data_ff[`ST_GUARD_LO+g]) flag_ff[g] <= 1'b0;
               cmp_v_ff[g]    <= chk;
               cmp_out_ff[g]  <= out;
               pipe_v_ff[g]   <= cmp_v_ff[g];
               pipe_out_ff[g] <= cmp_out_ff[g];
               // two cycles after compare; only checks, stop and disable move it
               if (sw_disable | sw_stop) GUARD_OUT[g] <= 1'b0;
               else if (pipe_v_ff[g]) GUARD_OUT[g] <= pipe_out_ff[g];
            end
         end
      end
   endgenerate

   // ****************************************
   // Interrupt and read data
   // ****************************************
   reg [31:0] rd_mux;
   always @* begin
      case (ARADDR)
         `OFF_CFG:    rd_mux = {27'h0000000, cfg_ff};
         `OFF_STATUS: rd_mux = {26'h0000000, OSC_ON, CONV_POWER_ON, flag_ff, done_ff};
         `OFF_IRQEN:  rd_mux = irqen_ff;
         `OFF_RESULT: rd_mux = {20'h00000, result_ff};
         `OFF_G1CFG:  rd_mux = {25'h0000000, g1cfg_ff};
         `OFF_G2CFG:  rd_mux = {{(32-NCH){1'b0}}, mask2_ff};
         `OFF_G3CFG:  rd_mux = {{(32-NCH){1'b0}}, mask3_ff};
         `OFF_G1THR:  rd_mux = thr_ff[0];
         `OFF_G2THR:  rd_mux = thr_ff[1];
         `OFF_G3THR:  rd_mux = thr_ff[2];
         default:     rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge CLK) begin
      if (RESET) begin
         RVALID <= 1'b0;
         RDATA  <= 32'h00000000;
         RRESP  <= 2'b00;
         IRQ    <= 1'b0;
      end else begin
         IRQ <= |(irqen_ff[3:1] & flag_ff) | (irqen_ff[0] & done_ff);
         if (rd_go) begin
            RVALID <= 1'b1;
            RDATA  <= rd_mux;
            RRESP  <= (ARADDR[1:0] == 2'b00 && ARADDR <= `OFF_G3THR && ARADDR != `OFF_CTRL) ?
                      2'b00 : 2'b10;
         end else if (RVALID & RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end

endmodule // adc_lowpower_window_guard

// ### adc_guard_checker.sv
/*
 Port checker for the converter guard block, bound to its top module.
 Assumes one clock CLK and a synchronous active-high RESET.
*/
`timescale 1ns/10ps
module adc_guard_checker (
   // Clock and reset
   input wire        CLK,
   input wire        RESET,
   // Register bus
   input wire        ARVALID,
   input wire        ARREADY,
   input wire        RVALID,
   input wire        RREADY,
   input wire [31:0] RDATA,
   input wire        BVALID,
   input wire        BREADY,
   input wire [1:0]  BRESP,
   // Converter and guards
   input wire        CONV_DONE,
   input wire        CONV_START,
   input wire        CONV_POWER_ON,
   input wire        OSC_ON,
   input wire [2:0]  GUARD_OUT,
   input wire        IRQ
);
   // ****************
   // Helper state
   // ****************
   reg [7:0] up_ff;
   reg       busy_ff;
   reg       rst_q_ff;
   // Powered time saturates so long idle stretches stay legal;
   // power that comes up straight out of reset needs no wake-up
   always @(posedge CLK) begin
      rst_q_ff <= RESET;
      if (RESET) begin
         up_ff <= 8'hFF;
      end else if (!CONV_POWER_ON && !rst_q_ff) begin
         up_ff <= 8'h00;
      end else if (up_ff != 8'hFF) begin
         up_ff <= up_ff + 8'h01;
      end
      if (RESET) begin
         busy_ff <= 1'b0;
      end else if (CONV_START) begin
         busy_ff <= 1'b1;
      end else if (CONV_DONE) begin
         busy_ff <= 1'b0;
      end
   end
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);
   a_out_rise_delay: assert property (|(GUARD_OUT & ~$past(GUARD_OUT)) |-> $past(CONV_DONE, 3))
      else $error("guard out rose off result timing");
   a_one_in_flight: assert property (CONV_START |-> !busy_ff)
      else $error("start while a conversion is open");
   a_wake_delay: assert property (CONV_START |-> CONV_POWER_ON && up_ff >= 8'h5F)
      else $error("start before startup delay");
   a_osc_follows: assert property (CONV_POWER_ON |-> OSC_ON)
      else $error("converter powered without oscillator");
   a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read answer late");
   a_read_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped");
   a_write_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped");
   a_reset_quiet: assert property ($fell(RESET) |-> GUARD_OUT == 3'h0 && !IRQ && !CONV_START)
      else $error("outputs active after reset");
   c_out_rise: cover property (|(GUARD_OUT & ~$past(GUARD_OUT)));
   c_power_off: cover property ($fell(CONV_POWER_ON));
   c_irq: cover property ($rose(IRQ));
endmodule // adc_guard_checker

bind adc_lowpower_window_guard adc_guard_checker chk (.*);

// ### adc_core_model.sv
/*
 Behavioural analog core: answers each start after CYCLES clocks.
 Assumes the bench sets channel and data before the start pulse.
*/
`timescale 1ns/10ps
module adc_core_model #(
   parameter CYCLES = 40
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Request and staged result
   input  wire        start,
   input  wire [4:0]  ch_in,
   input  wire [11:0] data_in,
   // Result to the block
   output reg         done,
   output reg  [4:0]  ch,
   output reg  [11:0] data,
   output reg         last
);
   reg [7:0] cnt_ff;
   always @(posedge clk) begin
      done <= 1'b0;
      if (rst) begin
         cnt_ff <= 8'h00;
         ch <= 5'h00;
         data <= 12'h000;
         last <= 1'b0;
      end else begin
         if (start) begin
            cnt_ff <= 8'(CYCLES);
         end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
         end
         if (cnt_ff == 8'h01) begin
            done <= 1'b1;
            ch <= ch_in;
            data <= data_in;
            last <= 1'b1;
         end else if (done) begin
            // Stale result must not pass for valid
            ch <= ~ch;
            data <= ~data;
            last <= ~last;
         end
      end
   end
endmodule // adc_core_model

// ### adc_lowpower_window_guard_bench.sv
/*
 Self-checking bench for the converter guard block with a core model.
 Assumes the register header and the core model are compiled first.
*/
`timescale 1ns/10ps
`include "adc_guard_regs.vh"
module adc_lowpower_window_guard_bench;
   reg         CLK, RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY, HW_TRIG;
   reg  [7:0]  AWADDR, ARADDR;
   reg  [31:0] WDATA, d;
   reg  [4:0]  cch;
   reg  [11:0] cdat;
   reg  [1:0]  r, br;
   wire        AWREADY, WREADY, BVALID, ARREADY, RVALID, CONV_DONE, SEQ_LAST;
   wire        CONV_START, CONV_POWER_ON, OSC_ON, IRQ;
   wire [1:0]  BRESP, RRESP;
   wire [31:0] RDATA;
   wire [4:0]  CONV_CH;
   wire [11:0] CONV_DATA;
   wire [2:0]  GUARD_OUT;
   wire [3:0]  WSTRB = 4'hF;
   integer     num_errors, checks, n, k, starts, s0;
   adc_lowpower_window_guard uut (.*);
   adc_core_model #(.CYCLES(40)) core (.clk(CLK), .rst(RESET), .start(CONV_START),
      .ch_in(cch), .data_in(cdat), .done(CONV_DONE), .ch(CONV_CH), .data(CONV_DATA),
      .last(SEQ_LAST));
   always @(posedge CLK) begin
      if (CONV_START === 1'b1) starts = starts + 1;
   end
   // ****************
   // Bus and helpers
   // ****************
   task wr(input [7:0] a, input [31:0] v);
      reg aw, w;
      begin
         @(posedge CLK);
         AWADDR <= a;
         WDATA <= v;
         AWVALID <= 1'b1;
         WVALID <= 1'b1;
         BREADY <= 1'b1;
         aw = 1'b1;
         w = 1'b1;
         while (aw || w) begin
            @(posedge CLK);
            if (aw && AWREADY === 1'b1) begin
               AWVALID <= 1'b0;
               aw = 1'b0;
            end
            if (w && WREADY === 1'b1) begin
               WVALID <= 1'b0;
               w = 1'b0;
            end
         end
         while (BVALID !== 1'b1) @(posedge CLK);
         br = BRESP;
         BREADY <= 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge CLK);
         ARADDR <= a;
         ARVALID <= 1'b1;
         RREADY <= 1'b1;
         do @(posedge CLK); while (ARREADY !== 1'b1);
         ARVALID <= 1'b0;
         while (RVALID !== 1'b1) @(posedge CLK);
         d = RDATA;
         r = RRESP;
         RREADY <= 1'b0;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task conv_go(input [4:0] c, input [11:0] v);
      begin
         @(posedge CLK);
         cch <= c;
         cdat <= v;
         wr(`OFF_CTRL, 32'h1);
      end
   endtask
   // Out signal settles three edges after the result edge
   task wait_done;
      begin
         do @(posedge CLK); while (CONV_DONE !== 1'b1);
         repeat (3) @(posedge CLK);
         #1;
      end
   endtask
   task conv(input [4:0] c, input [11:0] v);
      begin
         conv_go(c, v);
         wait_done;
      end
   endtask
   task wait_out(input [2:0] e);
      begin
         for (n = 0; GUARD_OUT !== e && n < 10; n = n + 1) @(posedge CLK);
         chk(GUARD_OUT, e);
      end
   endtask
   task wait_pwr(input e);
      begin
         for (n = 0; CONV_POWER_ON !== e && n < 300; n = n + 1) @(posedge CLK);
         chk(CONV_POWER_ON, e);
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", checks, num_errors);
         if (num_errors == 0 && checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // ****************
   // Scenarios
   // ****************
   task t_regs;
      begin
         rd(`OFF_G1THR);
         chk(d, `THR_RESET);
         rd(8'h2C);
         chk(r, 2'b10);
         rd(`OFF_CTRL);
         chk(r, 2'b10);
         wr(8'h2C, 32'h0);
         chk(br, 2'b10);
         wr(`OFF_IRQEN, 32'h0);
         chk(br, 2'b00);
         $display("regs done");
      end
   endtask
   task t_g1;
      begin
         wr(`OFF_IRQEN, 32'h2);
         wr(`OFF_G1THR, 32'h08000100);
         wr(`OFF_G1CFG, 32'h0000000F);
         conv(5'd3, 12'h900);
         chk(GUARD_OUT, 3'b001);
         chk(IRQ, 1'b1);
         conv(5'd5, 12'h000);
         chk(GUARD_OUT, 3'b001);
         conv(5'd3, 12'h400);
         chk(GUARD_OUT, 3'b000);
         conv(5'd3, 12'h0C0);
         chk(GUARD_OUT, 3'b001);
         rd(`OFF_STATUS);
         chk(d[3:1], 3'b001);
         wr(`OFF_STATUS, 32'hF);
         rd(`OFF_STATUS);
         chk(d[3:1], 3'b000);
         chk(IRQ, 1'b0);
         $display("guard one done");
      end
   endtask
   task t_res;
      begin
         wr(`OFF_G1CFG, 32'h1);
         wr(`OFF_G1THR, 32'h07C00040);
         for (k = 1; k < 4; k = k + 1) begin
            wr(`OFF_CFG, k << 3);
            conv(5'd1, 12'h7C0 | ((12'h001 << (2 * k)) - 12'h001));
            chk(GUARD_OUT, 3'b000);
         end
         wr(`OFF_CFG, 32'h0);
         conv(5'd1, 12'h7C1);
         chk(GUARD_OUT, 3'b001);
         $display("resolution done");
      end
   endtask
   task t_thr;
      begin
         wr(`OFF_STATUS, 32'hF);
         s0 = starts;
         conv_go(5'd1, 12'h900);
         while (starts == s0) @(posedge CLK);
         wr(`OFF_G1THR, 32'h0A000100);
         wait_done;
         chk(GUARD_OUT, 3'b001);
         chk(IRQ, 1'b0);
         conv(5'd1, 12'h900);
         chk(GUARD_OUT, 3'b000);
         $display("threshold update done");
      end
   endtask
   task t_g23;
      begin
         wr(`OFF_G2CFG, 32'h4);
         wr(`OFF_G3CFG, 32'h20);
         wr(`OFF_G2THR, 32'h02000100);
         wr(`OFF_G3THR, 32'h02000100);
         wr(`OFF_IRQEN, 32'h4);
         conv(5'd2, 12'h300);
         chk(GUARD_OUT, 3'b010);
         rd(`OFF_STATUS);
         chk(d[3:1], 3'b010);
         chk(IRQ, 1'b1);
         wr(`OFF_STATUS, 32'h4);
         rd(`OFF_STATUS);
         chk(d[2], 1'b0);
         chk(GUARD_OUT, 3'b010);
         wr(`OFF_CTRL, 32'h2);
         wait_out(3'b000);
         $display("guards two three done");
      end
   endtask
   task t_hold;
      begin
         wr(`OFF_CFG, 32'h7);
         // Earlier result still unread: the start must park in the wait
         s0 = starts;
         conv_go(5'd4, 12'h500);
         repeat (150) @(posedge CLK);
         chk(starts - s0, 0);
         wr(`OFF_STATUS, 32'h1);
         wait_done;
         s0 = starts;
         for (k = 0; k < 200; k = k + 1) begin
            @(posedge CLK);
            HW_TRIG <= k[4];
         end
         chk(starts - s0, 0);
         chk(CONV_POWER_ON, 1'b0);
         rd(`OFF_RESULT);
         while (starts == s0) @(posedge CLK);
         chk(CONV_POWER_ON, 1'b1);
         wait_done;
         wr(`OFF_CTRL, 32'h2);
         wr(`OFF_CFG, 32'h0);
         $display("hold done");
      end
   endtask
   task t_auto;
      begin
         wr(`OFF_CFG, 32'h2);
         wait_pwr(1'b0);
         chk(OSC_ON, 1'b0);
         s0 = starts;
         @(posedge CLK);
         HW_TRIG <= 1'b1;
         while (starts == s0) @(posedge CLK);
         HW_TRIG <= 1'b0;
         chk(CONV_POWER_ON, 1'b1);
         wait_done;
         wait_pwr(1'b0);
         $display("auto off done");
      end
   endtask
   task t_off;
      begin
         wr(`OFF_CFG, 32'h0);
         wait_pwr(1'b1);
         // Let the freshly powered converter settle before a start
         repeat (100) @(posedge CLK);
         conv(5'd1, 12'hFFF);
         chk(GUARD_OUT, 3'b001);
         wr(`OFF_CTRL, 32'h4);
         wait_out(3'b000);
         $display("disable done");
      end
   endtask
   // ****************
   // Run control
   // ****************
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   initial begin
      #300000;
      num_errors = num_errors + 1;
      report_and_stop;
   end
   initial begin
      RESET = 1'b1;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY, HW_TRIG} = 6'h00;
      {AWADDR, ARADDR, WDATA} = 48'h0;
      cch = 5'h00;
      cdat = 12'h000;
      num_errors = 0;
      checks = 0;
      starts = 0;
      repeat (6) @(posedge CLK);
      RESET <= 1'b0;
      t_regs;
      t_g1;
      t_res;
      t_thr;
      t_g23;
      t_hold;
      t_auto;
      t_off;
      report_and_stop;
   end
endmodule // adc_lowpower_window_guard_bench
